// ===== design/dram_ctl_defines.svh
// Constants for the DRAM address, refresh and power-down block
`ifndef DRAM_CTL_DEFINES_SVH
`define DRAM_CTL_DEFINES_SVH

// ****************************************************************
// Clock and refresh timing
// ****************************************************************
`define CLK_PERIOD_PS        32'd25000
`define REFRESH_PERIOD_PS    32'd15600000
// Longest interval rounds down
`define REFRESH_CYCLES       (`REFRESH_PERIOD_PS / `CLK_PERIOD_PS)
`define REFRESH_TIMER_W      10
`define REFRESH_TIMER_MAX    10'((`REFRESH_CYCLES) - 1)

// ****************************************************************
// Refresh queue and clock-enable delays
// ****************************************************************
`define REFRESH_QUEUE_DEPTH  3'h4
`define CKE_DELAY_CLOCKS     3'h4
`define NUM_ROWS             4
`define LAST_ROW             2'h3

// ****************************************************************
// Row size encodings of ROW_SIZE_SEL
// ****************************************************************
`define ROW_SIZE_8MB         3'h0
`define ROW_SIZE_16MB        3'h1
`define ROW_SIZE_32MB        3'h2
`define ROW_SIZE_64MB        3'h3
`define ROW_SIZE_128MB       3'h4

// ****************************************************************
// Memory address field positions
// ****************************************************************
`define MA_PRECHARGE_BIT     10
`define PAGE_OFFSET_MSB      8

`endif

// ===== design/dram_ctl_pkg.sv
// Types shared by the DRAM address, refresh and power-down block
`include "dram_ctl_defines.svh"

package dram_ctl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ROW       = 3'b001,
        ST_COL       = 3'b010,
        ST_REFRESH   = 3'b011,
        ST_PRECHARGE = 3'b100,
        ST_SUSP_WAIT = 3'b101,
        ST_SUSPEND   = 3'b110,
        ST_WAKE      = 3'b111
    } ctl_state_type;

    typedef logic [13:0] mem_addr_type;
    typedef logic [26:3] host_addr_type;
    typedef logic [2:0]  row_size_type;

endpackage

// ===== design/dram_addr_map.sv
// Host address to multiplexed row and column address translation
`timescale 1ns/10ps
`default_nettype none
`include "dram_ctl_defines.svh"

module dram_addr_map (
    input  wire logic                       ha_col_phase,
    input  wire logic                       ha_is_sdram,
    input  wire dram_ctl_pkg::row_size_type ha_row_size,
    input  wire dram_ctl_pkg::host_addr_type ha_addr,
    output logic [13:0]                     ma_out
);
    import dram_ctl_pkg::*;

    logic big_row;

    // Rows of 64 MB and above use the wide column map
    assign big_row = (ha_row_size >= `ROW_SIZE_64MB);

    // ****************************************************************
    // Row and column multiplexing
    // ****************************************************************
    // Column bits 7..0 span A10..A3, so with bit 8 this is the page offset
    always_comb begin
        ma_out = 14'h0000;
        if (!ha_col_phase) begin
            ma_out = {ha_addr[24], ha_addr[23], ha_addr[12], ha_addr[22:13], ha_addr[11]};
        end else begin
            ma_out[7:0] = ha_addr[10:3];
            if (ha_is_sdram) begin
                ma_out[11] = ha_addr[12];
                ma_out[`MA_PRECHARGE_BIT] = 1'b0; // No auto-precharge: pages stay open
                // Bank select rides A12 (two-bank) or A12/A13 row bits (four-bank)
                case (ha_row_size)
                    `ROW_SIZE_8MB: ma_out[9:8] = 2'h0;
                    `ROW_SIZE_16MB: ma_out[9:8] = {1'b0, ha_addr[23]};
                    `ROW_SIZE_32MB: ma_out[9:8] = {ha_addr[24], ha_addr[23]};
                    default: ma_out[9:8] = {ha_addr[26], ha_addr[25]};
                endcase
                if (ha_row_size >= `ROW_SIZE_32MB) begin
                    ma_out[13:12] = {ha_addr[24], ha_addr[23]};
                end
            end else begin
                // EDO geometries from 10x10 to 12x12 all fit this map
                ma_out[13:12] = {ha_addr[24], ha_addr[23]};
                ma_out[11] = ha_addr[26];
                ma_out[10] = big_row ? ha_addr[25] : ha_addr[12];
                case (ha_row_size)
                    `ROW_SIZE_8MB: ma_out[9:8] = {ha_addr[22], ha_addr[12]};
                    `ROW_SIZE_16MB: ma_out[9:8] = {ha_addr[12], ha_addr[23]};
                    default: ma_out[9:8] = {ha_addr[24], ha_addr[23]};
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== design/dram_refresh_pm.sv
// DRAM access sequencing, refresh queue and SDRAM power-down control
`timescale 1ns/10ps
`default_nettype none
`include "dram_ctl_defines.svh"

module dram_refresh_pm (
    input  wire logic                        MCLK,
    input  wire logic                        RST_N,
    input  wire logic                        MEM_REQ_PENDING,
    input  wire dram_ctl_pkg::host_addr_type MEM_REQ_ADDR,
    input  wire logic                        MEM_REQ_SDRAM,
    input  wire dram_ctl_pkg::row_size_type  MEM_REQ_ROW_SIZE,
    input  wire logic [3:0]                  ROW_POPULATED,
    input  wire logic [3:0]                  ROW_IS_SDRAM,
    input  wire logic                        REFRESH_QUEUE_DISABLE,
    input  wire logic                        SDRAM_PWR_MGMT_ENABLE,
    output logic [13:0]                      MEM_ADDR,
    output logic                             ROW_ADDR_VALID,
    output logic                             COL_ADDR_VALID,
    output logic                             MEM_REQ_DONE,
    output logic [3:0]                       REFRESH_ROW_STROBE,
    output logic                             PRECHARGE_ALL,
    output logic                             SDRAM_CKE,
    output logic                             SUSPENDED,
    output logic [2:0]                       REFRESH_QUEUED
);
    import dram_ctl_pkg::*;

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        ctl_state_type                  state;
        logic [`REFRESH_TIMER_W-1:0]    ref_timer;
        logic [2:0]                     ref_count;
        logic [1:0]                     ref_row;
        logic [2:0]                     delay;
        logic                           susp_mode;
        logic                           wake_for_req;
        logic                           pages_open;
        host_addr_type                  addr;
        logic                           is_sdram;
        row_size_type                   row_size;
        logic [13:0]                    ma;
        logic                           row_valid;
        logic                           col_valid;
        logic                           done;
        logic [3:0]                     ref_strobe;
        logic                           precharge;
        logic                           cke;
        logic                           suspended;
    } ctl_regs_type;

    ctl_regs_type ctl_reg;
    ctl_regs_type ctl_next;

    logic [13:0] mapped_addr;
    logic        col_phase;
    logic        sdram_present;
    logic        pm_allowed;
    logic        ref_tick;
    logic        ref_high;
    logic        ref_take;
    logic [2:0]  ref_count_upd;

    // ****************************************************************
    // Address translation
    // ****************************************************************
    // Row map while the row is registered, column map while the column is
    assign col_phase = (ctl_reg.state == ST_COL);

    // Row/column map and geometry support
    dram_addr_map u_addr_map (
        .ha_col_phase (col_phase),
        .ha_is_sdram  (ctl_reg.is_sdram),
        .ha_row_size  (ctl_reg.row_size),
        .ha_addr      (ctl_reg.addr),
        .ma_out       (mapped_addr)
    );

    // ****************************************************************
    // Power-management qualification and refresh priority
    // ****************************************************************
    // Mixed EDO/SDRAM arrays count as long as one SDRAM row is present
    assign sdram_present = |(ROW_POPULATED & ROW_IS_SDRAM);
    assign pm_allowed    = sdram_present && SDRAM_PWR_MGMT_ENABLE;
    // Each interval tick adds one request to the queue unless it already holds four
    assign ref_tick      = (ctl_reg.ref_timer == `REFRESH_TIMER_MAX);
    // With the queue disabled every request is urgent at once
    assign ref_high      = (ctl_reg.ref_count == `REFRESH_QUEUE_DEPTH) ||
                           (REFRESH_QUEUE_DISABLE && (ctl_reg.ref_count != 3'h0));

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.row_valid  = 1'b0;
        ctl_next.col_valid  = 1'b0;
        ctl_next.done       = 1'b0;
        ctl_next.ref_strobe = 4'h0;
        ctl_next.precharge  = 1'b0;
        ref_take = 1'b0;

        // Free-running interval timer; the host-side PCI/AGP traffic never stalls it
        if (ref_tick) begin
            ctl_next.ref_timer = '0;
        end else begin
            ctl_next.ref_timer = ctl_reg.ref_timer + 1'b1;
        end

        // Sequencer: accesses, refresh sweeps and the power-down path
        case (ctl_reg.state)
            // Urgent refresh, then access, then refresh, then power-down
            ST_IDLE: begin
                ctl_next.cke = 1'b1;
                ctl_next.susp_mode = 1'b0;
                ctl_next.suspended = 1'b0;
                if (ref_high) begin
                    ctl_next.state   = ST_REFRESH;
                    ctl_next.ref_row = 2'h0;
                end else if (MEM_REQ_PENDING) begin
                    ctl_next.state    = ST_ROW;
                    ctl_next.addr     = MEM_REQ_ADDR;
                    ctl_next.is_sdram = MEM_REQ_SDRAM;
                    ctl_next.row_size = MEM_REQ_ROW_SIZE;
                end else if (ctl_reg.ref_count != 3'h0) begin
                    ctl_next.state   = ST_REFRESH;
                    ctl_next.ref_row = 2'h0;
                end else if (pm_allowed && ctl_reg.pages_open) begin
                    ctl_next.state = ST_PRECHARGE;
                end else if (pm_allowed) begin
                    ctl_next.state = ST_SUSP_WAIT;
                    ctl_next.delay = `CKE_DELAY_CLOCKS;
                end
            end

            // One-cycle row address strobe
            ST_ROW: begin
                ctl_next.ma        = mapped_addr;
                ctl_next.row_valid = 1'b1;
                ctl_next.state     = ST_COL;
            end

            ST_COL: begin
                // Low nine bits now hold the page offset
                ctl_next.ma        = mapped_addr;
                ctl_next.col_valid = 1'b1;
                ctl_next.done      = 1'b1;
                ctl_next.pages_open = ctl_reg.pages_open | ctl_reg.is_sdram;
                ctl_next.state     = ST_IDLE;
            end

            ST_REFRESH: begin
                // One row per clock spreads the current surge; empty rows are skipped
                ctl_next.ref_strobe[ctl_reg.ref_row] = ROW_POPULATED[ctl_reg.ref_row];
                ctl_next.ref_row = ctl_reg.ref_row + 1'b1;
                if (ctl_reg.ref_row == `LAST_ROW) begin
                    ref_take = 1'b1;
                    if (!ctl_reg.susp_mode) begin
                        ctl_next.state = ST_IDLE;
                    end else if (ctl_reg.ref_count > 3'h1) begin
                        ctl_next.ref_row = 2'h0; // Back to back until empty
                    end else begin
                        ctl_next.state = ST_SUSP_WAIT;
                        ctl_next.delay = `CKE_DELAY_CLOCKS;
                    end
                end
            end

            // Close every SDRAM page before the clock stops
            ST_PRECHARGE: begin
                ctl_next.ma = 14'h0000;
                ctl_next.ma[`MA_PRECHARGE_BIT] = 1'b1; // All banks
                ctl_next.precharge  = 1'b1;
                ctl_next.pages_open = 1'b0;
                ctl_next.state = ST_SUSP_WAIT;
                ctl_next.delay = `CKE_DELAY_CLOCKS;
            end

            // Four-clock countdown with clock enable still high
            ST_SUSP_WAIT: begin
                // Flag suspend only when going ahead; an abort leaves it as it was
                if (!MEM_REQ_PENDING && pm_allowed) begin
                    ctl_next.susp_mode = 1'b1;
                    ctl_next.suspended = 1'b1;
                end
                if (MEM_REQ_PENDING || !pm_allowed) begin
                    // Clock enable is still high, so no wake delay is needed
                    ctl_next.state = ST_IDLE;
                end else if (ctl_reg.delay == 3'h1) begin
                    ctl_next.cke   = 1'b0;
                    ctl_next.state = ST_SUSPEND;
                end else begin
                    ctl_next.delay = ctl_reg.delay - 1'b1;
                end
            end

            // Powered down; a request, a full queue or power management no longer allowed wakes it
            ST_SUSPEND: begin
                ctl_next.cke = 1'b0;
                // Low-priority refresh stays queued here
                if (MEM_REQ_PENDING || !pm_allowed) begin
                    ctl_next.state = ST_WAKE;
                    ctl_next.wake_for_req = 1'b1;
                    ctl_next.cke   = 1'b1;
                    ctl_next.delay = `CKE_DELAY_CLOCKS;
                end else if (ctl_reg.ref_count == `REFRESH_QUEUE_DEPTH) begin
                    ctl_next.state = ST_WAKE;
                    ctl_next.wake_for_req = 1'b0;
                    ctl_next.cke   = 1'b1;
                    ctl_next.delay = `CKE_DELAY_CLOCKS;
                end
            end

            // Four clocks of wake latency are the price of the power saving
            ST_WAKE: begin
                ctl_next.cke = 1'b1;
                if (ctl_reg.delay == 3'h1) begin
                    ctl_next.ref_row = 2'h0;
                    if (ctl_reg.wake_for_req) begin
                        ctl_next.state = ST_IDLE;
                    end else begin
                        ctl_next.state = ST_REFRESH;
                    end
                end else begin
                    ctl_next.delay = ctl_reg.delay - 1'b1;
                end
            end

            // All eight codes are states; anything else falls back to idle
            default: begin
                ctl_next.state = ST_IDLE;
            end
        endcase

        // ****************************************************************
        // Refresh queue counter
        // ****************************************************************
        // New request and service in one clock cancel out, so none is lost
        ref_count_upd = ctl_reg.ref_count;
        if (ref_take) begin
            ref_count_upd = ref_count_upd - 1'b1;
        end
        if (ref_tick && (ref_count_upd != `REFRESH_QUEUE_DEPTH)) begin
            ref_count_upd = ref_count_upd + 1'b1;
        end
        ctl_next.ref_count = ref_count_upd;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Clock enable comes out of reset high, so no part starts powered down
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_reg <= '{state: ST_IDLE, row_size: `ROW_SIZE_8MB, cke: 1'b1, default: '0};
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // ****************************************************************
    // Outputs, each straight from the state record
    // ****************************************************************
    assign MEM_ADDR           = ctl_reg.ma;
    assign ROW_ADDR_VALID     = ctl_reg.row_valid;
    assign COL_ADDR_VALID     = ctl_reg.col_valid;
    assign MEM_REQ_DONE       = ctl_reg.done;
    assign REFRESH_ROW_STROBE = ctl_reg.ref_strobe;
    assign PRECHARGE_ALL      = ctl_reg.precharge;
    assign SDRAM_CKE          = ctl_reg.cke;
    assign SUSPENDED          = ctl_reg.suspended;
    // Queue depth is visible so the host side can see refresh backlog
    assign REFRESH_QUEUED     = ctl_reg.ref_count;

endmodule
`default_nettype wire

// ===== test/dram_refresh_pm_checker.sv
// Port assertions for the DRAM sequencing, refresh and power-down block
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_pm_checker (
    input wire logic                        MCLK,
    input wire logic                        RST_N,
    input wire dram_ctl_pkg::host_addr_type MEM_REQ_ADDR,
    input wire logic [3:0]                  ROW_POPULATED,
    input wire logic [3:0]                  ROW_IS_SDRAM,
    input wire logic                        REFRESH_QUEUE_DISABLE,
    input wire logic                        SDRAM_PWR_MGMT_ENABLE,
    input wire logic [13:0]                 MEM_ADDR,
    input wire logic                        ROW_ADDR_VALID,
    input wire logic                        COL_ADDR_VALID,
    input wire logic                        MEM_REQ_DONE,
    input wire logic [3:0]                  REFRESH_ROW_STROBE,
    input wire logic                        PRECHARGE_ALL,
    input wire logic                        SDRAM_CKE,
    input wire logic                        SUSPENDED,
    input wire logic [2:0]                  REFRESH_QUEUED
);
    import dram_ctl_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    // ****************************************************************
    // Access, refresh and power-down checks
    // ****************************************************************
    // Multi-step behaviours as named sequences
    sequence col_follows_s;
        ##1 (COL_ADDR_VALID && MEM_REQ_DONE);
    endsequence
    sequence quiet_after_wake_s;
        (REFRESH_ROW_STROBE == 4'h0 && !ROW_ADDR_VALID)[*4];
    endsequence
    sequence cke_drop_s;
        SDRAM_CKE[*3] ##1 (!SDRAM_CKE or (SDRAM_CKE ##1 !SUSPENDED));
    endsequence
    AST_ROW_MAP: assert property (ROW_ADDR_VALID |-> MEM_ADDR == {MEM_REQ_ADDR[24],
        MEM_REQ_ADDR[23], MEM_REQ_ADDR[12], MEM_REQ_ADDR[22:13], MEM_REQ_ADDR[11]})
        else $error("row address map wrong");
    AST_COL_LOW: assert property (COL_ADDR_VALID |-> MEM_ADDR[7:0] == MEM_REQ_ADDR[10:3])
        else $error("column low bits wrong");
    AST_ROW_THEN_COL: assert property (ROW_ADDR_VALID |-> col_follows_s)
        else $error("column phase missing");
    AST_DONE_WITH_COL: assert property (MEM_REQ_DONE == COL_ADDR_VALID)
        else $error("done not with column");
    AST_QUEUE_MAX: assert property (REFRESH_QUEUED <= 3'h4)
        else $error("refresh queue over four");
    AST_URGENT_FIRST: assert property (ROW_ADDR_VALID |-> $past(REFRESH_QUEUED, 2) != 3'h4
        && !($past(REFRESH_QUEUE_DISABLE, 2) && $past(REFRESH_QUEUED, 2) != 3'h0))
        else $error("access taken over urgent refresh");
    AST_STAGGER: assert property ($onehot0(REFRESH_ROW_STROBE)
        && (REFRESH_ROW_STROBE & ~ROW_POPULATED) == 4'h0) else $error("refresh strobe wrong");
    AST_PRECHARGE_FLAG: assert property (PRECHARGE_ALL |-> MEM_ADDR[10] && SDRAM_CKE)
        else $error("precharge flag wrong");
    AST_CKE_DROP: assert property ($rose(SUSPENDED) |-> cke_drop_s)
        else $error("clock enable drop timing wrong");
    AST_PM_GATE: assert property ($rose(SUSPENDED) |-> $past(SDRAM_PWR_MGMT_ENABLE)
        && ($past(ROW_POPULATED) & $past(ROW_IS_SDRAM)) != 4'h0) else $error("suspend not allowed");
    AST_CKE_AWAKE: assert property (!SUSPENDED |-> SDRAM_CKE)
        else $error("clock enable low outside suspend");
    AST_HIGH_WAKE: assert property (!SDRAM_CKE && REFRESH_QUEUED == 3'h4 |-> ##[1:2] SDRAM_CKE)
        else $error("no wake on full queue");
    AST_WAKE_DELAY: assert property ($rose(SDRAM_CKE) |-> quiet_after_wake_s)
        else $error("command too soon after wake");
endmodule
bind dram_refresh_pm dram_refresh_pm_checker dram_refresh_pm_checker_i (.MCLK, .RST_N,
    .MEM_REQ_ADDR, .ROW_POPULATED, .ROW_IS_SDRAM, .REFRESH_QUEUE_DISABLE, .SDRAM_PWR_MGMT_ENABLE,
    .MEM_ADDR, .ROW_ADDR_VALID, .COL_ADDR_VALID, .MEM_REQ_DONE, .REFRESH_ROW_STROBE,
    .PRECHARGE_ALL, .SDRAM_CKE, .SUSPENDED, .REFRESH_QUEUED);
`default_nettype wire

// ===== test/dram_array_model.sv
// Behavioural DIMM array: counts refreshes and precharges it honours
`timescale 1ns/10ps
`default_nettype none
module dram_array_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] strobe,
    input  wire logic       cke,
    input  wire logic       precharge,
    output logic [15:0]     row_hits [0:3],
    output logic [7:0]      precharges
);
    // ****************************************************************
    // Command capture
    // ****************************************************************
    // Powered-down parts ignore commands, so a stray one is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) row_hits[i] <= 16'h0000;
            precharges <= 8'h00;
        end else if (cke) begin
            for (int i = 0; i < 4; i++) row_hits[i] <= row_hits[i] + 16'(strobe[i]);
            if (precharge) precharges <= precharges + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== test/dram_refresh_pm_tb.sv
// Self-checking bench for the DRAM sequencing, refresh and power block
`timescale 1ns/10ps
`default_nettype none
module dram_refresh_pm_tb;
    import dram_ctl_pkg::*;
    logic          MCLK = 1'b0;
    logic          RST_N = 1'b0;
    logic          MEM_REQ_PENDING = 1'b0;
    host_addr_type MEM_REQ_ADDR = '0;
    logic          MEM_REQ_SDRAM = 1'b0;
    row_size_type  MEM_REQ_ROW_SIZE = 3'h0;
    logic [3:0]    ROW_POPULATED = 4'hF;
    logic [3:0]    ROW_IS_SDRAM = 4'h0;
    logic          REFRESH_QUEUE_DISABLE = 1'b0;
    logic          SDRAM_PWR_MGMT_ENABLE = 1'b0;
    logic [13:0]   MEM_ADDR;
    logic          ROW_ADDR_VALID, COL_ADDR_VALID, MEM_REQ_DONE, PRECHARGE_ALL;
    logic          SDRAM_CKE, SUSPENDED, seen_susp;
    logic [3:0]    REFRESH_ROW_STROBE;
    logic [2:0]    REFRESH_QUEUED, qmax;
    logic [15:0]   row_hits [0:3];
    logic [15:0]   base [0:3];
    logic [7:0]    precharges, pbase;
    int            fail_count = 0;
    int            comparisons = 0;
    // ****************************************************************
    // Clock, design and memory array
    // ****************************************************************
    always #12.5 MCLK = ~MCLK;
    dram_refresh_pm dram_refresh_pm_i (.MCLK, .RST_N, .MEM_REQ_PENDING, .MEM_REQ_ADDR,
        .MEM_REQ_SDRAM, .MEM_REQ_ROW_SIZE, .ROW_POPULATED, .ROW_IS_SDRAM, .REFRESH_QUEUE_DISABLE,
        .SDRAM_PWR_MGMT_ENABLE, .MEM_ADDR, .ROW_ADDR_VALID, .COL_ADDR_VALID, .MEM_REQ_DONE,
        .REFRESH_ROW_STROBE, .PRECHARGE_ALL, .SDRAM_CKE, .SUSPENDED, .REFRESH_QUEUED);
    dram_array_model dram_array_model_i (.clk(MCLK), .rst_n(RST_N), .strobe(REFRESH_ROW_STROBE),
        .cke(SDRAM_CKE), .precharge(PRECHARGE_ALL), .row_hits(row_hits), .precharges(precharges));
    // ****************************************************************
    // Reference address model and helpers
    // ****************************************************************
    function automatic logic [13:0] row_of(host_addr_type a);
        return {a[24], a[23], a[12], a[22:13], a[11]};
    endfunction
    // Blank table cells are driven low; precharge flag stays low on access
    function automatic logic [13:0] col_of(host_addr_type a, logic sd, int rs);
        logic [13:0] c;
        c = 14'h0000;
        c[7:0] = a[10:3];
        if (sd) begin
            c[11] = a[12];
            if (rs >= 2) c[13:12] = {a[24], a[23]};
            if (rs == 1) c[8] = a[23];
            if (rs == 2) c[9:8] = {a[24], a[23]};
            if (rs >= 3) c[9:8] = {a[26], a[25]};
        end else begin
            c[13:8] = {a[24], a[23], a[26], a[12], a[22], a[12]};
            if (rs == 1) c[9:8] = {a[12], a[23]};
            if (rs == 2) c[9:8] = {a[24], a[23]};
            if (rs >= 3) c[10:8] = {a[25], a[24], a[23]};
        end
        return c;
    endfunction
    task automatic close_out();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Inputs move 1 ns after the edge so sampling never races
    task automatic step();
        @(posedge MCLK);
        #1;
    endtask
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig !== lvl) begin
            step();
            n++;
            if (n > lim) begin
                check("wait", 16'(lvl), 16'(sig));
                close_out();
            end
        end
    endtask
    task automatic run(int n);
        qmax = 3'h0;
        seen_susp = 1'b0;
        repeat (n) begin
            step();
            if (REFRESH_QUEUED > qmax) qmax = REFRESH_QUEUED;
            seen_susp = seen_susp | SUSPENDED;
        end
    endtask
    task automatic snap();
        for (int i = 0; i < 4; i++) base[i] = row_hits[i];
        pbase = precharges;
    endtask
    // Request held until the done cycle, then released
    task automatic access(host_addr_type a, logic sd, int rs);
        MEM_REQ_ADDR = a;
        MEM_REQ_SDRAM = sd;
        MEM_REQ_ROW_SIZE = row_size_type'(rs);
        MEM_REQ_PENDING = 1'b1;
        wait_for(ROW_ADDR_VALID, 1'b1, 3000);
        check("row", 16'(row_of(a)), 16'(MEM_ADDR));
        step();
        check("col", 16'(col_of(a, sd, rs)), 16'(MEM_ADDR));
        check("done", 16'h1, 16'(MEM_REQ_DONE));
        MEM_REQ_PENDING = 1'b0;
        step();
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(38));
        repeat (3) @(posedge MCLK);
        #1;
        RST_N = 1'b1;
        step();
        check("cke", 16'h1, 16'(SDRAM_CKE));
        for (int rs = 0; rs < 5; rs++) begin
            for (int k = 0; k < 4; k++) access(host_addr_type'($urandom), k[0], rs);
        end
        access('1, 1'b1, 4);
        ROW_POPULATED = 4'hB;
        snap();
        run(1300);
        check("row2", base[2], row_hits[2]);
        check("row1", row_hits[0] - base[0], row_hits[1] - base[1]);
        check("sweeps", 16'h1, 16'(row_hits[3] - base[3] >= 16'h2));
        // Endless requests starve refresh until the queue fills
        ROW_POPULATED = 4'hF;
        MEM_REQ_ADDR = host_addr_type'($urandom);
        MEM_REQ_ROW_SIZE = 3'h3;
        MEM_REQ_PENDING = 1'b1;
        snap();
        run(2700);
        check("qmax", 16'h4, 16'(qmax));
        check("urgent", 16'h1, 16'(row_hits[0] != base[0]));
        MEM_REQ_PENDING = 1'b0;
        run(100);
        check("drain", 16'h0, 16'(REFRESH_QUEUED));
        REFRESH_QUEUE_DISABLE = 1'b1;
        MEM_REQ_PENDING = 1'b1;
        run(1300);
        check("qoff", 16'h1, 16'(qmax));
        MEM_REQ_PENDING = 1'b0;
        REFRESH_QUEUE_DISABLE = 1'b0;
        SDRAM_PWR_MGMT_ENABLE = 1'b1;
        run(100);
        check("edo only", 16'h0, 16'(seen_susp));
        ROW_IS_SDRAM = 4'h3;
        snap();
        access(host_addr_type'($urandom), 1'b1, 3);
        wait_for(SUSPENDED, 1'b1, 700);
        wait_for(SDRAM_CKE, 1'b0, 20);
        check("precharge", pbase + 8'h01, precharges);
        snap();
        wait_for(SDRAM_CKE, 1'b1, 3000);
        wait_for(SDRAM_CKE, 1'b0, 300);
        check("burst", base[2] + 16'h4, row_hits[2]);
        access(host_addr_type'($urandom), 1'b1, 2);
        SDRAM_PWR_MGMT_ENABLE = 1'b0;
        wait_for(SDRAM_CKE, 1'b1, 20);
        run(50);
        check("pm off", 16'h1, 16'(SDRAM_CKE));
        close_out();
    end
endmodule
`default_nettype wire
